// ==== sut_status_update.sv ====
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1: Status bits change only on an internal event or a host command.
// R2: Immediate-class changes take effect in the cycle the command is written.
// R3: Acceptance-class changes apply within 150 us after the command.
// R4: With speakerphone enabled the acceptance bound becomes 250 us.
// R5: Event-class changes follow their event only, not command timing.
// R6: Ready sets on acceptance, clears at once; busy sets on acceptance, clears on event.
// R7: Abort, caller data, fax tone, fault set on events, clear on acceptance.
// R8: Carrier to voice flags set on event, clear on event end or acceptance; the code follows the level only, so acceptance never clears them.
// R9: Queue-empty follows events only; peripheral sets on event, clears on acceptance.
// R10: On-hook gap selection accepts alert-tone gaps of 16 ms or more.
// R11: Off-hook operation requires alert-tone gaps of at least 50 ms.
// R12: Reading the status word returns all flags and changes nothing.
module sut_status_update
  import sut_pkg::*;
#(
  parameter int ACCEPT_DELAY     = ACCEPT_CYCLES,
  parameter int ACCEPT_SPK_DELAY = ACCEPT_SPK_CYCLES,
  parameter int GAP_ON_DELAY     = GAP_ONHOOK_CYCLES,
  parameter int GAP_OFF_DELAY    = GAP_OFFHOOK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event pulses that set flags or clear the busy flag.
  input  wire logic        abortEvent,
  input  wire logic        callerDataEvent,
  input  wire logic        faxToneEvent,
  input  wire logic        faultEvent,
  input  wire logic        doneEvent,
  input  wire logic        peripheralEvent,
  // Event levels that follow detectors.
  input  wire logic        carrierLevel,
  input  wire logic        progressLevel,
  input  wire logic        signalLevel,
  input  wire logic        keypadLevel,
  input  wire logic        alertToneSegment,
  input  wire logic        voiceLevel,
  input  wire logic        queueEmptyLevel,
  // Interrupt.
  output logic             irq
);

  // ==========================================================================
  // Registers
  logic [FLAG_COUNT-1:0] status_reg;
  logic [FLAG_COUNT-1:0] status_next;
  logic [FLAG_COUNT-1:0] pendClear_reg;
  logic [1:0]            config_reg;
  logic [2:0]            irqStat_reg;
  logic [2:0]            irqMask_reg;
  logic [COUNT_WIDTH-1:0] delay_reg;
  sut_state_t            state_reg;
  sut_state_t            state_next;
  logic                  gapAccepted;
  logic                  gapSeen_reg;
  logic                  alertValid_reg;

  // ==========================================================================
  // Bus decode; the slave answers in the first access cycle.
  logic accessPhase;
  logic busWrite;
  logic busRead;
  logic hitStatus;
  logic hitCommand;
  logic hitConfig;
  logic hitIrqStat;
  logic hitIrqMask;
  logic hitAny;
  logic cmdWrite;
  logic cmdStart;
  logic [FLAG_COUNT-1:0] cmdClear;
  logic [31:0] readData;

  assign accessPhase = psel && penable;
  assign busWrite    = accessPhase && pwrite;
  assign busRead     = accessPhase && !pwrite;
  assign hitStatus   = paddr == STATUS_OFFSET;
  assign hitCommand  = paddr == COMMAND_OFFSET;
  assign hitConfig   = paddr == CONFIG_OFFSET;
  assign hitIrqStat  = paddr == IRQ_STAT_OFFSET;
  assign hitIrqMask  = paddr == IRQ_MASK_OFFSET;
  assign hitAny      = hitStatus || hitCommand || hitConfig || hitIrqStat || hitIrqMask;

  // A command is refused while one is still waiting for acceptance.
  assign cmdWrite = busWrite && hitCommand && (state_reg == ST_IDLE);
  assign cmdStart = cmdWrite && pwdata[CMD_START_BIT];
  assign cmdClear = pwdata[CMD_CLEAR_LSB +: FLAG_COUNT];

  // Status reads have no side effect on any flag.
  assign readData = hitStatus  ? {17'h0_0000, status_reg} :             // [R12]
                    hitConfig  ? {30'h0000_0000, config_reg} :
                    hitIrqStat ? {29'h0000_0000, irqStat_reg} :
                    hitIrqMask ? {29'h0000_0000, irqMask_reg} : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hitAny;
      prdata  <= (psel && !penable && !pwrite) ? readData : prdata;
    end
  end

  // ==========================================================================
  // Acceptance sequencer: the command waits its acceptance delay, which the
  // speakerphone mode lengthens; a constant delay keeps the bound exact.
  logic [COUNT_WIDTH-1:0] acceptLimit;
  logic                   accepted;

  assign acceptLimit = config_reg[CFG_SPEAKER_BIT] ? COUNT_WIDTH'(ACCEPT_SPK_DELAY) // [R4]
                                                   : COUNT_WIDTH'(ACCEPT_DELAY);    // [R3]
  // The apply cycle follows acceptance, so the count stops two short of the limit.
  assign accepted    = (state_reg == ST_ACCEPT) && (delay_reg + 2'd2 >= acceptLimit); // [R3]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   if (cmdWrite) state_next = ST_ACCEPT;
      ST_ACCEPT: if (accepted) state_next = ST_APPLY;
      ST_APPLY:  state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  logic                  startPend_reg;
  logic                  applyNow;
  assign applyNow = state_reg == ST_APPLY;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      delay_reg     <= '0;
      pendClear_reg <= '0;
      startPend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      delay_reg <= (state_reg == ST_ACCEPT) ? delay_reg + 1'b1 : '0;
      if (cmdWrite) begin
        pendClear_reg <= cmdClear;
        startPend_reg <= cmdStart;
      end
    end
  end

  // ==========================================================================
  // Alert tone qualification by gap length.
  sut_gap_filter #(
    .GAP_ON_CYCLES  (GAP_ON_DELAY),
    .GAP_OFF_CYCLES (GAP_OFF_DELAY)
  ) gapFilter (
    .clock           (clock),
    .reset           (reset),
    .onhookGapSelect (config_reg[CFG_ONHOOK_BIT]),
    .toneSegment     (alertToneSegment),
    .gapAccepted     (gapAccepted)
  );

  logic alertRise;
  // A gap of exactly the limit qualifies, so the filter output is taken as it stands.
  assign alertRise = alertToneSegment && (gapSeen_reg || gapAccepted) && !alertValid_reg; // [R10]

  always_ff @(posedge clock) begin
    if (reset) begin
      gapSeen_reg    <= 1'b0;
      alertValid_reg <= 1'b0;
    end else begin
      gapSeen_reg    <= gapAccepted ? 1'b1 : (alertToneSegment ? 1'b0 : gapSeen_reg);
      alertValid_reg <= alertToneSegment;
    end
  end

  // ==========================================================================
  // Flag update: every change has an event or a command behind it.
  logic [FLAG_COUNT-1:0] setEvent;
  logic [FLAG_COUNT-1:0] levelMask;
  logic [FLAG_COUNT-1:0] levelValue;
  logic [FLAG_COUNT-1:0] acceptClr;

  assign setEvent = FLAG_COUNT'({peripheralEvent, 6'h00, faultEvent, 1'b0, faxToneEvent,
                                 2'h0, callerDataEvent, abortEvent, 1'b0}) << 0; // [R7]
  assign levelMask  = 15'h3E58;
  assign levelValue = {1'b0, queueEmptyLevel, voiceLevel, gapAccepted, alertRise,
                       keypadLevel, 2'h0, signalLevel, 1'b0, progressLevel,
                       carrierLevel, 3'h0};
  assign acceptClr  = applyNow ? (pendClear_reg & ~(15'h2000)) : '0; // [R9]

  always_comb begin
    status_next = status_reg;
    status_next = status_next & ~acceptClr;                   // [R3] [R8]
    status_next = (status_next & ~levelMask) | (levelValue & levelMask) |
                  (status_next & levelMask & ~acceptClr & levelValue); // [R5] [R8]
    status_next = status_next | setEvent;                      // [R1] [R5]
    if (cmdWrite) begin
      status_next[READY_BIT] = 1'b0;                           // [R2] [R6]
    end
    if (applyNow) begin
      status_next[READY_BIT] = 1'b1;                           // [R6]
      status_next[BUSY_BIT]  = status_next[BUSY_BIT] | startPend_reg; // [R6]
    end
    if (doneEvent) begin
      status_next[BUSY_BIT] = 1'b0;                            // [R6]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================================================
  // Configuration and interrupts; a new event wins over a clearing write.
  logic [2:0] irqEvents;
  assign irqEvents = {alertRise, doneEvent, applyNow};

  always_ff @(posedge clock) begin
    if (reset) begin
      config_reg  <= CONFIG_RESET;
      irqStat_reg <= IRQ_RESET;
      irqMask_reg <= IRQ_RESET;
      irq         <= 1'b0;
    end else begin
      if (busWrite && hitConfig) begin
        config_reg <= pwdata[1:0];
      end
      if (busWrite && hitIrqMask) begin
        irqMask_reg <= pwdata[2:0];
      end
      irqStat_reg <= (irqStat_reg & ~((busWrite && hitIrqStat) ? pwdata[2:0] : 3'h0))
                     | irqEvents;
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

endmodule : sut_status_update
`default_nettype wire

// ==== sut_pkg.sv ====
package sut_pkg;

  // ==========================================================================
  // Register map, byte addresses on the APB
  localparam logic [7:0] STATUS_OFFSET  = 8'h00;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET  = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

  // ==========================================================================
  // Status word bit positions
  localparam int READY_BIT   = 0;
  localparam int ABORT_BIT   = 1;
  localparam int CALLER_BIT  = 2;
  localparam int CARRIER_BIT = 3;
  localparam int PROGRESS_BIT = 4;
  localparam int FAX_BIT     = 5;
  localparam int SIGNAL_BIT  = 6;
  localparam int FAULT_BIT   = 7;
  localparam int BUSY_BIT    = 8;
  localparam int KEYPAD_BIT  = 9;
  localparam int ALERT_BIT   = 10;
  localparam int GAP_BIT     = 11;
  localparam int VOICE_BIT   = 12;
  localparam int QUEUE_BIT   = 13;
  localparam int PERIPH_BIT  = 14;
  localparam int FLAG_COUNT  = 15;

  // Command word fields.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CLEAR_LSB = 16;

  // Configuration word fields.
  localparam int CFG_SPEAKER_BIT = 0;
  localparam int CFG_ONHOOK_BIT  = 1;

  // Event ids for the interrupt status word.
  localparam int EVT_READY_BIT  = 0;
  localparam int EVT_DONE_BIT   = 1;
  localparam int EVT_ALERT_BIT  = 2;

  // ==========================================================================
  // Reset values
  localparam logic [FLAG_COUNT-1:0] STATUS_RESET = 15'h0001;
  localparam logic [1:0]            CONFIG_RESET = 2'h0;
  localparam logic [2:0]            IRQ_RESET    = 3'h0;

  // ==========================================================================
  // Timing
  localparam int CLOCK_MHZ         = 100;
  localparam int ACCEPT_US         = 150;
  localparam int ACCEPT_SPK_US     = 250;
  localparam int GAP_ONHOOK_MS     = 16;
  localparam int GAP_OFFHOOK_MS    = 50;
  localparam int ACCEPT_CYCLES     = ACCEPT_US * CLOCK_MHZ;
  localparam int ACCEPT_SPK_CYCLES = ACCEPT_SPK_US * CLOCK_MHZ;
  localparam int GAP_ONHOOK_CYCLES  = GAP_ONHOOK_MS * 1000 * CLOCK_MHZ;
  localparam int GAP_OFFHOOK_CYCLES = GAP_OFFHOOK_MS * 1000 * CLOCK_MHZ;
  localparam int COUNT_WIDTH        = 23;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCEPT = 3'b010,
    ST_APPLY  = 3'b100
  } sut_state_t;

endpackage : sut_pkg

// ==== sut_gap_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module sut_gap_filter
  import sut_pkg::*;
#(
  parameter int GAP_ON_CYCLES  = GAP_ONHOOK_CYCLES,
  parameter int GAP_OFF_CYCLES = GAP_OFFHOOK_CYCLES
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Control.
  input  wire logic onhookGapSelect,
  // Raw tone segment from the detector and qualified gap.
  input  wire logic toneSegment,
  output logic      gapAccepted
);

  // ==========================================================================
  // Silence between segments counts only when long enough for the hook mode.
  logic [COUNT_WIDTH-1:0] silenceCount_reg;
  logic [COUNT_WIDTH-1:0] gapLimit;

  assign gapLimit = onhookGapSelect ? COUNT_WIDTH'(GAP_ON_CYCLES)   // [R10]
                                    : COUNT_WIDTH'(GAP_OFF_CYCLES); // [R11]

  always_ff @(posedge clock) begin
    if (reset || toneSegment) begin
      silenceCount_reg <= '0;
      gapAccepted      <= 1'b0;
    end else begin
      if (silenceCount_reg < gapLimit) begin
        silenceCount_reg <= silenceCount_reg + 1'b1;
      end
      gapAccepted <= (silenceCount_reg + 1'b1) >= gapLimit;
    end
  end

endmodule : sut_gap_filter
`default_nettype wire

// ==== sut_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ====================
// Port checks for the status block.
module sut_checker
  import sut_pkg::*;
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt.
  input wire logic        irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  wire logic setup;
  wire logic mapped;
  assign setup = psel && !penable;
  assign mapped = paddr inside {STATUS_OFFSET, COMMAND_OFFSET, CONFIG_OFFSET,
    IRQ_STAT_OFFSET, IRQ_MASK_OFFSET};
  // A late answer would stretch every command and blur the immediate class.
  chk_answer_prompt: assert property (setup |=> pready && penable)
    else $error("answer not in first access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  chk_ready_cause: assert property (!setup |=> !pready)
    else $error("answer without request");
  chk_unmapped_err: assert property (setup && !mapped && !pwrite
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_unmapped_werr: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access without error");
  chk_mapped_ok: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  chk_status_width: assert property (setup && !pwrite && paddr == STATUS_OFFSET
    |=> prdata[31:FLAG_COUNT] == '0)
    else $error("status high bits not zero");
  chk_write_quiet: assert property (setup && pwrite |=> $stable(prdata))
    else $error("read data moved on a write");
  chk_irq_quiet: assert property ($fell(reset) |-> !irq ##1 !irq)
    else $error("interrupt without cause after reset");
endmodule : sut_checker

bind sut_status_update sut_checker chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== sut_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// ====================
// Host controller: an APB master running one transfer at a time.
module sut_host (
  // Clock.
  input  wire logic        clock,
  // Request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  // Answer.
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // An idle cycle before each setup keeps every signal to one change per time step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : sut_host
`default_nettype wire

// ==== status_update_timing_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ====================
// Self-checking bench for the status block.
module status_update_timing_tb;
  import sut_pkg::*;
  localparam int ACC = 20;
  localparam int SPK = 30;
  localparam int GON = 16;
  localparam int GOFF = 50;
  localparam logic [31:0] EVM = 32'h0000_40A6;
  localparam int LP [6] = '{CARRIER_BIT, PROGRESS_BIT, SIGNAL_BIT, KEYPAD_BIT, VOICE_BIT,
    QUEUE_BIT};
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  pulse = 6'h00;
  logic [5:0]  lvl = 6'h00;
  logic        tone = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          seed = 32'h0000_1fee;
  int          errors = 0;
  int          n_tests = 0;
  sut_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sut_status_update #(.ACCEPT_DELAY(ACC), .ACCEPT_SPK_DELAY(SPK), .GAP_ON_DELAY(GON),
    .GAP_OFF_DELAY(GOFF)) dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .abortEvent(pulse[0]), .callerDataEvent(pulse[1]),
    .faxToneEvent(pulse[2]), .faultEvent(pulse[3]), .doneEvent(pulse[4]),
    .peripheralEvent(pulse[5]), .carrierLevel(lvl[0]), .progressLevel(lvl[1]),
    .signalLevel(lvl[2]), .keypadLevel(lvl[3]), .alertToneSegment(tone),
    .voiceLevel(lvl[4]), .queueEmptyLevel(lvl[5]), .irq(irq));
  initial begin
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] lvlMap(input logic [5:0] l);
    lvlMap = 32'h0000_0001;
    for (int i = 0; i < 6; i++) begin
      lvlMap[LP[i]] = l[i];
    end
  endfunction : lvlMap
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdata, rerr);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, rdata, rerr);
  endtask : rd
  task automatic pulseEv(input logic [5:0] p);
    pulse <= p;
    @(posedge clock);
    pulse <= 6'h00;
  endtask : pulseEv
  // Polling costs three cycles a read, so the upper bound carries four cycles of slack.
  task automatic cmd(input logic [31:0] d, input int lo, input int hi);
    time t0;
    int  cyc;
    wr(COMMAND_OFFSET, d);
    t0 = $time;
    rd(STATUS_OFFSET);
    chk(rdata[READY_BIT], 1'b0);
    do rd(STATUS_OFFSET); while (rdata[READY_BIT] !== 1'b1);
    cyc = int'(($time - t0) / 10);
    chk(cyc > lo && cyc <= hi + 4, 1'b1);
  endtask : cmd
  task automatic gapTry(input logic onhook_gap_select, input int gap, input logic exp);
    wr(CONFIG_OFFSET, {30'h0, onhook_gap_select, 1'b0});
    tone <= 1'b1;
    repeat (5) @(posedge clock);
    tone <= 1'b0;
    wr(IRQ_STAT_OFFSET, 32'h0000_0004);
    repeat (gap - 3) @(posedge clock);
    tone <= 1'b1;
    repeat (5) @(posedge clock);
    tone <= 1'b0;
    rd(IRQ_STAT_OFFSET);
    chk(rdata[EVT_ALERT_BIT], exp);
  endtask : gapTry
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(STATUS_OFFSET);
    chk(rdata, 32'h0000_0001);
    rd(8'h14);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0000_0000);
    $display("test reset and refusal done");
    pulseEv(6'b10_1111);
    rd(STATUS_OFFSET);
    chk(rdata, EVM | 32'h0000_0001);
    rd(STATUS_OFFSET);
    chk(rdata, EVM | 32'h0000_0001);
    cmd((EVM << 16) | 32'h0000_0001, 0, ACC);
    rd(STATUS_OFFSET);
    chk(rdata, 32'h0000_0101);
    wr(IRQ_MASK_OFFSET, 32'h0000_0002);
    pulseEv(6'b01_0000);
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    rd(STATUS_OFFSET);
    chk(rdata, 32'h0000_0001);
    wr(IRQ_STAT_OFFSET, 32'h0000_0002);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    wr(IRQ_MASK_OFFSET, 32'h0000_0000);
    pulseEv(6'b01_0000);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    rd(IRQ_STAT_OFFSET);
    chk(rdata[EVT_DONE_BIT], 1'b1);
    $display("test command classes done");
    wr(CONFIG_OFFSET, 32'h0000_0001);
    cmd(32'h0000_0000, ACC, SPK);
    wr(CONFIG_OFFSET, 32'h0000_0000);
    $display("test speakerphone bound done");
    for (int i = 0; i < 8; i++) begin
      lvl <= 6'($random(seed));
      repeat (2) @(posedge clock);
      rd(STATUS_OFFSET);
      chk(rdata, lvlMap(lvl));
    end
    lvl <= 6'h00;
    repeat (2) @(posedge clock);
    rd(STATUS_OFFSET);
    chk(rdata, 32'h0000_0001);
    $display("test level flags done");
    tone <= 1'b0;
    repeat (GOFF) @(posedge clock);
    rd(STATUS_OFFSET);
    chk(rdata, 32'h0000_0801);
    gapTry(1'b1, GON - 1, 1'b0);
    gapTry(1'b1, GON, 1'b1);
    gapTry(1'b0, GOFF - 1, 1'b0);
    gapTry(1'b0, GOFF, 1'b1);
    $display("test alert gaps done");
    finish_test();
  end
endmodule : status_update_timing_tb
`default_nettype wire
